// ===== dtc_assertions.sv
// port-level checks of the dual timer counter unit
`timescale 1ns/100ps
module dtc_assertions (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  // register bus
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // acks and flags
  input wire logic        unit_zero_vector_ack_i,
  input wire logic        unit_one_vector_ack_i,
  input wire logic        ext_irq_one_ack_i,
  input wire logic        unit_zero_overflow_flag_o,
  input wire logic        unit_one_overflow_flag_o,
  input wire logic        ext_irq_one_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_reset_quiet: assert property ($rose(reset_n_i) |->
    !unit_zero_overflow_flag_o && !unit_one_overflow_flag_o && !s_axi_bvalid_o)
    else $error("flag or answer active out of reset");
  a_ovf0_clear: assert property ($fell(unit_zero_overflow_flag_o) |->
    $past(unit_zero_vector_ack_i) || s_axi_bvalid_o)
    else $error("unit zero flag fell without ack or write");
  a_ovf1_clear: assert property ($fell(unit_one_overflow_flag_o) |->
    $past(unit_one_vector_ack_i) || s_axi_bvalid_o)
    else $error("unit one flag fell without ack or write");
  a_ext1_clear: assert property ($fell(ext_irq_one_flag_o) |->
    $past(ext_irq_one_ack_i) || s_axi_bvalid_o)
    else $error("irq one flag fell without ack or write");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data late");
  a_resp_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o ##1 !s_axi_bvalid_o)
    else $error("write response repeated");
  a_rdata_upper: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule

bind dtc_top dtc_assertions u_chk (.*);

// ===== dtc_map.svh
// register indices, field positions, reset values and timing counts of the dual timer
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// register indices, byte address is four times the index
`define DTC_IDX_CTL       10'h088
`define DTC_IDX_MODE      10'h089
`define DTC_IDX_LO0       10'h08A
`define DTC_IDX_LO1       10'h08B
`define DTC_IDX_HI0       10'h08C
`define DTC_IDX_HI1       10'h08D

// timer_control_status fields
`define DTC_CTL_OVF1      7
`define DTC_CTL_RUN1      6
`define DTC_CTL_OVF0      5
`define DTC_CTL_RUN0      4
`define DTC_CTL_EIF1      3
`define DTC_CTL_EIT1      2
`define DTC_CTL_EIF0      1
`define DTC_CTL_EIT0      0

// timer_mode_control fields
`define DTC_MOD_GATE1     7
`define DTC_MOD_FSEL1     6
`define DTC_MOD_M1_HI     5
`define DTC_MOD_M1_LO     4
`define DTC_MOD_GATE0     3
`define DTC_MOD_FSEL0     2
`define DTC_MOD_M0_HI     1
`define DTC_MOD_M0_LO     0

// reset values
`define DTC_CTL_RESET     8'h00
`define DTC_MODE_RESET    8'h00
`define DTC_CNT_RESET     8'h00

// oscillator periods per machine cycle
`define DTC_OSC_PER_MC    6

// bus responses
`define DTC_RESP_OKAY     2'h0
`define DTC_RESP_SLVERR   2'h2

`endif

// ===== dtc_pin_model.sv
// far-side event source driving the count pins
`timescale 1ns/100ps
`include "dtc_map.svh"
module dtc_pin_model (
  // clock
  input  wire logic       mclk_i,
  // burst request
  input  wire logic       go_i,
  input  wire logic [3:0] hold_i,
  input  wire logic [7:0] num_i,
  // event pin and status
  output      logic       pin_o,
  output      logic       busy_o
);
  int left_ff;
  int cnt_ff;

  initial begin
    pin_o = 1'b1;
    busy_o = 1'b0;
  end

  always @(posedge mclk_i) begin
    if (go_i && !busy_o) begin
      left_ff <= 2 * num_i;
      cnt_ff <= 0;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (cnt_ff == `DTC_OSC_PER_MC * hold_i - 1) begin
        cnt_ff <= 0;
        pin_o <= !pin_o;
        left_ff <= left_ff - 1;
        busy_o <= left_ff > 1;
      end else begin
        cnt_ff <= cnt_ff + 1;
      end
    end
  end
endmodule

// ===== dtc_pkg.sv
// types of the dual timer counter unit
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE,
    DTC_MODE_CASCADE,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  typedef enum logic [2:0] {
    DTC_SEL_CTL,
    DTC_SEL_MODE,
    DTC_SEL_LO0,
    DTC_SEL_LO1,
    DTC_SEL_HI0,
    DTC_SEL_HI1,
    DTC_SEL_NONE
  } dtc_sel_e;

  typedef logic [7:0] dtc_byte_t;

endpackage

// ===== dtc_top.sv
// dual timer counter unit with an AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dtc_map.svh"

module dtc_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // write address channel
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output      logic        s_axi_awready_o,
  // write data channel
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output      logic        s_axi_wready_o,
  // write response channel
  output      logic [1:0]  s_axi_bresp_o,
  output      logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // read address channel
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output      logic        s_axi_arready_o,
  // read data channel
  output      logic [31:0] s_axi_rdata_o,
  output      logic [1:0]  s_axi_rresp_o,
  output      logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // count and irq pins
  input  wire logic        unit_zero_count_pin_i,
  input  wire logic        unit_one_count_pin_i,
  input  wire logic        ext_irq_zero_pin_i,
  input  wire logic        ext_irq_one_pin_i,
  // vector acknowledges from the interrupt controller
  input  wire logic        unit_zero_vector_ack_i,
  input  wire logic        unit_one_vector_ack_i,
  input  wire logic        ext_irq_zero_ack_i,
  input  wire logic        ext_irq_one_ack_i,
  // flags towards the interrupt controller
  output      logic        unit_zero_overflow_flag_o,
  output      logic        unit_one_overflow_flag_o,
  output      logic        ext_irq_zero_flag_o,
  output      logic        ext_irq_one_flag_o
);

  // address decode shared by read and write
  function automatic dtc_pkg::dtc_sel_e dtc_decode(input logic [11:0] addr);
    dtc_pkg::dtc_sel_e sel;
    sel = dtc_pkg::DTC_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[11:2])
        `DTC_IDX_CTL:  sel = dtc_pkg::DTC_SEL_CTL;
        `DTC_IDX_MODE: sel = dtc_pkg::DTC_SEL_MODE;
        `DTC_IDX_LO0:  sel = dtc_pkg::DTC_SEL_LO0;
        `DTC_IDX_LO1:  sel = dtc_pkg::DTC_SEL_LO1;
        `DTC_IDX_HI0:  sel = dtc_pkg::DTC_SEL_HI0;
        `DTC_IDX_HI1:  sel = dtc_pkg::DTC_SEL_HI1;
        default:       sel = dtc_pkg::DTC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // one count step, returns overflow, high byte, low byte
  function automatic logic [16:0] dtc_step(input logic [1:0] mode,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [16:0] r;
    logic [15:0] s16;
    logic [12:0] s13;
    r   = {1'b0, hi, lo};
    s16 = {hi, lo} + 16'h0001;
    s13 = {hi, lo[4:0]} + 13'h0001;
    case (dtc_pkg::dtc_mode_e'(mode))
      dtc_pkg::DTC_MODE_PRESCALE: begin
        // upper low bits held, rollover flags
        r = {&{hi, lo[4:0]}, s13[12:5], lo[7:5], s13[4:0]};
      end
      dtc_pkg::DTC_MODE_CASCADE: begin
        r = {&{hi, lo}, s16};
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      default: begin
        r = {&lo, hi, lo + 8'h01};
      end
    endcase
    return r;
  endfunction

  // registers
  logic [2:0]          mc_cnt_ff;
  logic [7:0]          ctl_ff;
  logic [7:0]          mode_ff;
  dtc_pkg::dtc_byte_t  cnt_ff [4];
  dtc_pkg::dtc_byte_t  pval_ff [4];
  logic [3:0]          pend_ff;
  logic [1:0]          cpin_ff;
  logic [1:0]          cfall_ff;
  logic [1:0]          ipin_ff;
  logic                aw_have_ff;
  logic [11:0]         aw_addr_ff;
  logic                w_have_ff;
  logic [7:0]          w_data_ff;
  logic                w_strb_ff;
  logic                awready_ff;
  logic                wready_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;

  // combinational
  logic                tick;
  logic                do_wr;
  logic                wr_en;
  dtc_pkg::dtc_sel_e   wr_sel;
  dtc_pkg::dtc_sel_e   rd_sel;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                nxt_aw_have;
  logic                nxt_w_have;
  logic                nxt_bvalid;
  logic                nxt_rvalid;
  logic [7:0]          rd_byte;
  logic [1:0]          m0;
  logic [1:0]          m1;
  logic                split0;
  logic                en0;
  logic                en1;
  logic                th0_en;
  logic [16:0]         step0;
  logic [16:0]         step1;
  logic                ovf0_set;
  logic                ovf1_set;
  logic                eif0_set;
  logic                eif1_set;
  logic [7:0]          nxt_ctl;
  dtc_pkg::dtc_byte_t  nxt_cnt [4];

  // machine cycle divider
  assign tick = (mc_cnt_ff == 3'(`DTC_OSC_PER_MC - 1));

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mc_cnt_ff <= 3'h0;
    end else if (tick) begin
      mc_cnt_ff <= 3'h0;
    end else begin
      mc_cnt_ff <= mc_cnt_ff + 3'h1;
    end
  end

  // pin sampling once per machine cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpin_ff  <= 2'h0;
      cfall_ff <= 2'h0;
      ipin_ff  <= 2'h0;
    end else if (tick) begin
      cpin_ff  <= {unit_one_count_pin_i, unit_zero_count_pin_i};
      // fall counted at the next machine cycle
      cfall_ff <= cpin_ff & ~{unit_one_count_pin_i, unit_zero_count_pin_i};
      ipin_ff  <= {ext_irq_one_pin_i, ext_irq_zero_pin_i};
    end
  end

  // bus handshakes
  assign aw_take     = s_axi_awvalid_i & awready_ff;
  assign w_take      = s_axi_wvalid_i & wready_ff;
  assign ar_take     = s_axi_arvalid_i & arready_ff;
  assign do_wr       = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_sel      = dtc_decode(aw_addr_ff);
  assign wr_en       = do_wr & w_strb_ff & (wr_sel != dtc_pkg::DTC_SEL_NONE);
  assign nxt_aw_have = do_wr ? 1'b0 : (aw_take | aw_have_ff);
  assign nxt_w_have  = do_wr ? 1'b0 : (w_take | w_have_ff);
  assign nxt_bvalid  = do_wr | (bvalid_ff & ~s_axi_bready_i);
  assign nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready_i);
  assign rd_sel      = dtc_decode(s_axi_araddr_i);

  // write side of the slave
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_have_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_strb_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DTC_RESP_OKAY;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      awready_ff <= ~nxt_aw_have & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_have & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata_i[7:0];
        w_strb_ff <= s_axi_wstrb_i[0];
      end
      if (do_wr) begin
        bresp_ff <= (wr_sel == dtc_pkg::DTC_SEL_NONE) ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end
    end
  end

  // read mux
  always_comb begin
    case (rd_sel)
      dtc_pkg::DTC_SEL_CTL:  rd_byte = ctl_ff;
      dtc_pkg::DTC_SEL_MODE: rd_byte = mode_ff;
      dtc_pkg::DTC_SEL_LO0:  rd_byte = cnt_ff[0];
      dtc_pkg::DTC_SEL_LO1:  rd_byte = cnt_ff[1];
      dtc_pkg::DTC_SEL_HI0:  rd_byte = cnt_ff[2];
      dtc_pkg::DTC_SEL_HI1:  rd_byte = cnt_ff[3];
      default:               rd_byte = 8'h00;
    endcase
  end

  // read side of the slave
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `DTC_RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= {24'h000000, rd_byte};
        rresp_ff <= (rd_sel == dtc_pkg::DTC_SEL_NONE) ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
      end
    end
  end

  assign m0     = {mode_ff[`DTC_MOD_M0_HI], mode_ff[`DTC_MOD_M0_LO]};
  assign m1     = {mode_ff[`DTC_MOD_M1_HI], mode_ff[`DTC_MOD_M1_LO]};
  assign split0 = (dtc_pkg::dtc_mode_e'(m0) == dtc_pkg::DTC_MODE_SPLIT);

  assign en0 = tick & ctl_ff[`DTC_CTL_RUN0]
             & (~mode_ff[`DTC_MOD_GATE0] | ipin_ff[0])
             // counter pace set by two-sample fall
             & (~mode_ff[`DTC_MOD_FSEL0] | cfall_ff[0]);
  // mode 3 stops unit one; run bit lent to split high byte
  assign en1 = tick & (dtc_pkg::dtc_mode_e'(m1) != dtc_pkg::DTC_MODE_SPLIT)
             & (split0 | ctl_ff[`DTC_CTL_RUN1])
             & (~mode_ff[`DTC_MOD_GATE1] | ipin_ff[1])
             & (~mode_ff[`DTC_MOD_FSEL1] | cfall_ff[1]);
  // split high byte counts machine cycles
  assign th0_en = tick & split0 & ctl_ff[`DTC_CTL_RUN1];

  assign step0 = dtc_step(m0, cnt_ff[0], cnt_ff[2]);
  assign step1 = dtc_step(m1, cnt_ff[1], cnt_ff[3]);

  assign ovf0_set = en0 & step0[16];
  // split high byte owns unit one flag
  assign ovf1_set = split0 ? (th0_en & (&cnt_ff[2])) : (en1 & step1[16]);

  assign eif0_set = tick & ~ext_irq_zero_pin_i & (~ctl_ff[`DTC_CTL_EIT0] | ipin_ff[0]);
  assign eif1_set = tick & ~ext_irq_one_pin_i & (~ctl_ff[`DTC_CTL_EIT1] | ipin_ff[1]);

  // count byte next values
  always_comb begin
    nxt_cnt[0] = en0 ? step0[7:0] : cnt_ff[0];
    nxt_cnt[1] = en1 ? step1[7:0] : cnt_ff[1];
    nxt_cnt[3] = en1 ? step1[15:8] : cnt_ff[3];
    nxt_cnt[2] = split0 ? cnt_ff[2] + 8'(th0_en) : (en0 ? step0[15:8] : cnt_ff[2]);
    // pending software value replaces the count at the tick
    for (int i = 0; i < 4; i++) begin
      if (tick && pend_ff[i]) begin
        nxt_cnt[i] = pval_ff[i];
      end
    end
  end

  // count bytes touched only by counting or writes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '{default: `DTC_CNT_RESET};
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // software writes held until the next machine cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_ff <= 4'h0;
      pval_ff <= '{default: `DTC_CNT_RESET};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_en && (wr_sel == dtc_pkg::dtc_sel_e'(3'(i + 2)))) begin
          pend_ff[i] <= 1'b1;
          pval_ff[i] <= w_data_ff;
        end else if (tick) begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // control register next value, hardware set wins
  always_comb begin
    nxt_ctl = ctl_ff;
    // whole byte written by software, flags included
    if (wr_en && (wr_sel == dtc_pkg::DTC_SEL_CTL)) begin
      nxt_ctl = w_data_ff;
    end
    nxt_ctl[`DTC_CTL_OVF0] = (nxt_ctl[`DTC_CTL_OVF0] & ~unit_zero_vector_ack_i) | ovf0_set;
    nxt_ctl[`DTC_CTL_OVF1] = (nxt_ctl[`DTC_CTL_OVF1] & ~unit_one_vector_ack_i) | ovf1_set;
    nxt_ctl[`DTC_CTL_EIF0] = (nxt_ctl[`DTC_CTL_EIF0] & ~ext_irq_zero_ack_i) | eif0_set;
    nxt_ctl[`DTC_CTL_EIF1] = (nxt_ctl[`DTC_CTL_EIF1] & ~ext_irq_one_ack_i) | eif1_set;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_ff <= `DTC_CTL_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ff <= `DTC_MODE_RESET;
    end else if (wr_en && (wr_sel == dtc_pkg::DTC_SEL_MODE)) begin
      mode_ff <= w_data_ff;
    end
  end

  // outputs
  assign s_axi_awready_o           = awready_ff;
  assign s_axi_wready_o            = wready_ff;
  assign s_axi_bvalid_o            = bvalid_ff;
  assign s_axi_bresp_o             = bresp_ff;
  assign s_axi_arready_o           = arready_ff;
  assign s_axi_rvalid_o            = rvalid_ff;
  assign s_axi_rdata_o             = rdata_ff;
  assign s_axi_rresp_o             = rresp_ff;
  assign unit_zero_overflow_flag_o = ctl_ff[`DTC_CTL_OVF0];
  assign unit_one_overflow_flag_o  = ctl_ff[`DTC_CTL_OVF1];
  assign ext_irq_zero_flag_o       = ctl_ff[`DTC_CTL_EIF0];
  assign ext_irq_one_flag_o        = ctl_ff[`DTC_CTL_EIF1];

endmodule

// ===== tb.sv
// self-checking bench of the dual timer counter unit
`timescale 1ns/100ps
`include "dtc_map.svh"
module tb;
  localparam int A_CTL = `DTC_IDX_CTL * 4;
  localparam int A_MODE = `DTC_IDX_MODE * 4;
  localparam int A_LO0 = `DTC_IDX_LO0 * 4;
  localparam int A_LO1 = `DTC_IDX_LO1 * 4;
  localparam int A_HI0 = `DTC_IDX_HI0 * 4;
  logic mclk_i = 1'b0, reset_n_i = 1'b0;
  logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic unit_zero_count_pin_i, unit_one_count_pin_i;
  logic ext_irq_zero_pin_i = 1'b1, ext_irq_one_pin_i = 1'b1;
  logic unit_zero_vector_ack_i = 1'b0, unit_one_vector_ack_i = 1'b0;
  logic ext_irq_zero_ack_i = 1'b0, ext_irq_one_ack_i = 1'b0;
  logic unit_zero_overflow_flag_o, unit_one_overflow_flag_o;
  logic ext_irq_zero_flag_o, ext_irq_one_flag_o;
  logic go = 1'b0, busy, pin;
  logic [3:0] hold = 4'h1;
  logic [7:0] num = 8'h0;
  int err_count = 0, checks_done = 0, cyc = 0, seed = 32'ha2cbc28a;

  dtc_top DUT (.*);
  dtc_pin_model u_src (.mclk_i(mclk_i), .go_i(go), .hold_i(hold), .num_i(num),
                       .pin_o(pin), .busy_o(busy));
  assign unit_zero_count_pin_i = pin;
  assign unit_one_count_pin_i = pin;

  initial forever #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  function automatic int near(int s, int e);
    return (s - e <= 2 && e - s <= 2) ? e : s;
  endfunction

  task automatic wr(input int a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a[11:0];
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input int a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr_i <= a[11:0];
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic wrc(input int a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk(r, `DTC_RESP_OKAY, "write resp");
  endtask

  task automatic rdc(input int a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk(r, `DTC_RESP_OKAY, "read resp");
  endtask

  task automatic run_for(input logic [7:0] c, input int n);
    repeat (8) @(posedge mclk_i);
    wrc(A_CTL, c);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic rd0(output int c);
    logic [31:0] l, h;
    logic [1:0] r;
    rd(A_LO0, l, r);
    rd(A_HI0, h, r);
    c = {h[7:0], l[7:0]};
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int c0, v, t;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    for (int k = 0; k < 6; k++) rdc(A_CTL + 4 * k, 0);
    rd(12'h400, d, r);
    chk(r, `DTC_RESP_SLVERR, "unmapped resp");
    chk(d, 0, "unmapped data");
    wr(A_CTL + 1, 8'h10, 4'hF, r);
    chk(r, `DTC_RESP_SLVERR, "misaligned resp");
    wr(A_MODE, 8'hFF, 4'h0, r);
    chk(r, `DTC_RESP_OKAY, "strobe-off resp");
    rdc(A_MODE, 0);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & 'hFF;
      wrc(A_MODE, v[7:0]);
      rdc(A_MODE, v);
      v = $random(seed) & 'h55;
      wrc(A_CTL, v[7:0]);
      rdc(A_CTL, v);
    end
    wrc(A_CTL, 8'h00);
    wrc(A_MODE, 8'h01);
    wrc(A_LO0, 8'h40);
    wrc(A_HI0, 8'h00);
    c0 = cyc + 8;
    run_for(8'h10, 600);
    wrc(A_CTL, 8'h00);
    v = (cyc - c0) / `DTC_OSC_PER_MC + 'h40;
    rd0(t);
    chk(near(t, v), v, "timer count");
    wrc(A_MODE, 8'h55);
    wrc(A_LO0, 8'h00);
    wrc(A_LO1, 8'h00);
    run_for(8'h50, 0);
    t = 0;
    for (int hd = 1; hd <= 3; hd += 2) begin
      num <= 8'h05 + hd[7:0];
      hold <= hd[3:0];
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      @(posedge mclk_i);
      c0 = 0;
      while (busy && c0 < 4000) begin
        @(posedge mclk_i);
        c0++;
      end
      repeat (18) @(posedge mclk_i);
      t += 5 + hd;
      rdc(A_LO0, t);
      rdc(A_LO1, t);
    end
    wrc(A_CTL, 8'h00);
    wrc(A_MODE, 8'h09);
    wrc(A_LO0, 8'h00);
    wrc(A_HI0, 8'h00);
    ext_irq_zero_pin_i <= 1'b0;
    run_for(8'h10, 120);
    rdc(A_LO0, 0);
    chk(ext_irq_zero_flag_o, 1, "level flag");
    ext_irq_zero_pin_i <= 1'b1;
    c0 = cyc;
    repeat (12) @(posedge mclk_i);
    ext_irq_zero_ack_i <= 1'b1;
    @(posedge mclk_i);
    ext_irq_zero_ack_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(ext_irq_zero_flag_o, 0, "ack clear");
    repeat (300) @(posedge mclk_i);
    wrc(A_CTL, 8'h00);
    v = (cyc - c0) / `DTC_OSC_PER_MC - 1;
    rd0(t);
    chk(near(t, v), v, "gated count");
    wrc(A_CTL, 8'h04);
    ext_irq_one_pin_i <= 1'b0;
    repeat (14) @(posedge mclk_i);
    chk(ext_irq_one_flag_o, 1, "edge flag");
    ext_irq_one_ack_i <= 1'b1;
    @(posedge mclk_i);
    ext_irq_one_ack_i <= 1'b0;
    repeat (14) @(posedge mclk_i);
    chk(ext_irq_one_flag_o, 0, "edge once");
    ext_irq_one_pin_i <= 1'b1;
    wrc(A_MODE, 8'h0A);
    wrc(A_HI0, 8'hFE);
    wrc(A_LO0, 8'hFD);
    run_for(8'h10, 60);
    chk(unit_zero_overflow_flag_o, 1, "reload flag");
    rd(A_CTL, d, r);
    chk(d[5], 1, "ctl flag");
    ext_irq_zero_pin_i <= 1'b0;
    repeat (14) @(posedge mclk_i);
    unit_zero_vector_ack_i <= 1'b1;
    @(posedge mclk_i);
    unit_zero_vector_ack_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(unit_zero_overflow_flag_o, 0, "vector ack");
    rdc(A_HI0, 'hFE);
    rd(A_LO0, d, r);
    chk(d[7:1], 7'h7F, "reload value");
    ext_irq_zero_pin_i <= 1'b1;
    wrc(A_CTL, 8'h00);
    wrc(A_MODE, 8'h00);
    wrc(A_LO0, 8'hDE);
    wrc(A_HI0, 8'hFF);
    run_for(8'h10, 30);
    chk(unit_zero_overflow_flag_o, 1, "13-bit rollover");
    wrc(A_CTL, 8'h00);
    rdc(A_HI0, 0);
    wrc(A_MODE, 8'h33);
    wrc(A_LO0, 8'h11);
    wrc(A_HI0, 8'hF8);
    wrc(A_LO1, 8'h22);
    run_for(8'h40, 72);
    chk(unit_one_overflow_flag_o, 1, "split flag");
    unit_one_vector_ack_i <= 1'b1;
    @(posedge mclk_i);
    unit_one_vector_ack_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(unit_one_overflow_flag_o, 0, "split ack");
    wrc(A_CTL, 8'h00);
    rdc(A_LO0, 'h11);
    rdc(A_LO1, 'h22);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
